// File: logic/sep_top.sv
// Purpose: command and status port of the serial memory controller
// Assumes: memory uses two address bytes and a byte-wide status register
// Notes: writes to the command word or buffer are ignored while pending
`timescale 1ns/1ps
module sep_top
  import sep_pkg::*;
(
  input  wire logic        CLK,        // core clock, 50 MHz
  input  wire logic        RST_N,      // asynchronous reset, active low
  input  wire logic        REG_WR,     // register write strobe
  input  wire logic        REG_RD,     // register read strobe
  input  wire logic [11:0] REG_ADDR,   // register byte address
  input  wire logic [31:0] REG_WDATA,  // register write data
  output logic [31:0]      REG_RDATA,  // register read data, one cycle after REG_RD
  output logic             MEM_SCLK,   // memory serial clock pin
  output logic             MEM_CS_N,   // memory chip select, active low
  output logic             MEM_MOSI,   // memory serial data out
  input  wire logic        MEM_MISO    // memory serial data in
);
  import sep_pkg::*;

  logic        rst_meta_q, rst_sync_q, rst_n_i;
  logic [12:0] blk_q, blk_d;
  logic        top_q, top_d;
  logic [2:0]  op_q, op_d;
  logic [7:0]  sdata_q, sdata_d;
  logic [31:0] buf_q, buf_d;
  logic [2:0]  freq_q, freq_d;
  logic [1:0]  pres_q, pres_d;
  logic [1:0]  wid_q, wid_d;
  logic [2:0]  cur_q, cur_d;
  logic [31:0] rdata_q, rdata_d;
  sep_state_t  st_q, st_d;
  logic        start_d, boot_q;
  logic [55:0] tx_d;
  logic [5:0]  nbits_d;
  logic [4:0]  half;
  logic        eng_busy, eng_done;
  logic [31:0] eng_rx;
  logic [31:0] csr_rd, rx_swap;
  logic [15:0] byte_addr;
  logic        pend;
  logic        csr_wr, buf_wr, freq_wr, op_ok;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n_i = rst_sync_q;

  assign pend      = (st_q != ST_IDLE);
  assign csr_wr    = REG_WR && (REG_ADDR == SEP_CSR_OFS);
  assign buf_wr    = REG_WR && (REG_ADDR == SEP_BUF_OFS);
  assign freq_wr   = REG_WR && (REG_ADDR == SEP_FREQ_OFS);
  assign op_ok     = (REG_WDATA[SEP_OP_LSB +: 3] != OP_RSV0) &&
                     (REG_WDATA[SEP_OP_LSB +: 3] != OP_RSV7);
  assign byte_addr = {top_q, blk_q, 2'b00};
  assign rx_swap   = {eng_rx[7:0], eng_rx[15:8], eng_rx[23:16], eng_rx[31:24]};

  always_comb
  begin
    case (freq_q)
      3'h1: half = SEP_H1;
      3'h2: half = SEP_H2;
      3'h3: half = SEP_H3;
      3'h4: half = SEP_H4;
      3'h5: half = SEP_H5;
      3'h6: half = SEP_H5;
      default: half = SEP_H0;
    endcase
  end

  always_comb
  begin
    csr_rd = 32'h0;
    csr_rd[SEP_BLK_LSB +: SEP_BLK_W] = blk_q;
    csr_rd[SEP_OP_LSB +: 3]          = op_q;
    csr_rd[SEP_PRES_LSB +: 2]        = pres_q;
    csr_rd[SEP_PEND_BIT]             = pend;
    csr_rd[SEP_TOP_BIT]              = top_q;
    csr_rd[SEP_WID_LSB +: 2]         = wid_q;
    csr_rd[SEP_SDATA_LSB +: 8]       = sdata_q;
  end

  // frame to send for a given operation code
  function automatic logic [55:0] frame(input logic [2:0] op);
    case (op)
      OP_WRSR:  frame = {SPI_WRSR, sdata_q & SEP_WP_MASK, 40'h0};
      OP_WRITE: frame = {SPI_WRITE, byte_addr, buf_q[7:0], buf_q[15:8],
                         buf_q[23:16], buf_q[31:24]};
      OP_READ:  frame = {SPI_READ, byte_addr, 32'h0};
      OP_WRDI:  frame = {SPI_WRDI, 48'h0};
      OP_RDSR:  frame = {SPI_RDSR, 48'h0};
      OP_WREN:  frame = {SPI_WREN, 48'h0};
      default:  frame = 56'h0;
    endcase
  endfunction

  function automatic logic [5:0] frame_bits(input logic [2:0] op);
    case (op)
      OP_WRSR, OP_RDSR:  frame_bits = SEP_BITS_SR;
      OP_WRITE, OP_READ: frame_bits = SEP_BITS_WD;
      default:           frame_bits = SEP_BITS_OP;
    endcase
  endfunction

  always_comb
  begin
    blk_d   = blk_q;
    top_d   = top_q;
    op_d    = op_q;
    sdata_d = sdata_q;
    buf_d   = buf_q;
    freq_d  = freq_q;
    pres_d  = pres_q;
    wid_d   = wid_q;
    cur_d   = cur_q;
    st_d    = st_q;
    start_d = 1'b0;
    tx_d    = 56'h0;
    nbits_d = SEP_BITS_OP;
    rdata_d = rdata_q;
    if (REG_RD)
    begin
      if (REG_ADDR == SEP_CSR_OFS)
        rdata_d = csr_rd;
      else if (REG_ADDR == SEP_BUF_OFS)
        rdata_d = buf_q;
      else if (REG_ADDR == SEP_FREQ_OFS)
        rdata_d = {29'h0, freq_q};
      else
        rdata_d = 32'h0;
    end
    if (freq_wr)
      freq_d = REG_WDATA[2:0];
    case (st_q)
      ST_BOOT_SR:
      begin
        tx_d    = {SPI_RDSR, 48'h0};
        nbits_d = SEP_BITS_SR;
        start_d = boot_q && !eng_busy;
        if (eng_done)
        begin
          if (eng_rx[7:0] == SEP_NO_DEV)
          begin
            pres_d = PRES_NONE;
            st_d   = ST_IDLE;
          end
          else
          begin
            st_d = ST_BOOT_RD;
          end
        end
      end
      ST_BOOT_RD:
      begin
        tx_d    = {SPI_READ, 16'h0000, 32'h0};
        nbits_d = SEP_BITS_SIG;
        start_d = !eng_busy && !eng_done;
        if (eng_done)
        begin
          st_d = ST_IDLE;
          if (eng_rx[7:0] == SEP_SIG)
          begin
            pres_d = PRES_OK;
            wid_d  = WID_TWO;
          end
          else
          begin
            pres_d = PRES_NOSIG;
            wid_d  = WID_NONE;
          end
        end
      end
      ST_IDLE:
      begin
        if (buf_wr)
          buf_d = REG_WDATA;
        if (csr_wr)
        begin
          blk_d   = REG_WDATA[SEP_BLK_LSB +: SEP_BLK_W];
          top_d   = REG_WDATA[SEP_TOP_BIT];
          op_d    = REG_WDATA[SEP_OP_LSB +: 3];
          sdata_d = REG_WDATA[SEP_SDATA_LSB +: 8];
          if (op_ok)
          begin
            cur_d = REG_WDATA[SEP_OP_LSB +: 3];
            st_d  = ST_RUN;
          end
        end
      end
      ST_RUN:
      begin
        tx_d    = frame(cur_q);
        nbits_d = frame_bits(cur_q);
        start_d = !eng_busy && !eng_done;
        if (eng_done)
        begin
          st_d = ST_IDLE;
          if (cur_q == OP_READ)
            buf_d = rx_swap;
          else if (cur_q == OP_RDSR)
            sdata_d = eng_rx[7:0];
        end
      end
      default:
      begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      blk_q   <= SEP_BLK_RST;
      top_q   <= 1'b0;
      op_q    <= OP_RSV0;
      sdata_q <= SEP_SDATA_RST;
      buf_q   <= SEP_BUF_RST;
      freq_q  <= SEP_FREQ_RST;
      pres_q  <= PRES_NONE;
      wid_q   <= WID_NONE;
      cur_q   <= OP_RSV0;
      st_q    <= ST_BOOT_SR;
      rdata_q <= 32'h0;
      boot_q  <= 1'b1;
    end
    else
    begin
      blk_q   <= blk_d;
      top_q   <= top_d;
      op_q    <= op_d;
      sdata_q <= sdata_d;
      buf_q   <= buf_d;
      freq_q  <= freq_d;
      pres_q  <= pres_d;
      wid_q   <= wid_d;
      cur_q   <= cur_d;
      st_q    <= st_d;
      rdata_q <= rdata_d;
      boot_q  <= boot_q && !start_d;
    end
  end

  assign REG_RDATA = rdata_q;

  sep_shift u_shift (
    .clk   (CLK),
    .rst_n (rst_n_i),
    .start (start_d),
    .half  (half),
    .nbits (nbits_d),
    .tx    (tx_d),
    .busy  (eng_busy),
    .done  (eng_done),
    .rx    (eng_rx),
    .sclk  (MEM_SCLK),
    .cs_n  (MEM_CS_N),
    .mosi  (MEM_MOSI),
    .miso  (MEM_MISO)
  );

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n_i);

  property p_start_pend;
    (st_q == ST_IDLE) && csr_wr && op_ok |=> pend ##1 MEM_CS_N == 1'b0;
  endproperty
  a_start_pend: assert property (p_start_pend) else $error("command did not start");

  property p_done_clear;
    (st_q == ST_RUN) && eng_done |=> !pend && !csr_rd[SEP_PEND_BIT];
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("pending not cleared");

  property p_wrsr_mask;
    start_d && (st_q == ST_RUN) && (cur_q == OP_WRSR) |->
      tx_d[55:48] == SPI_WRSR && (tx_d[47:40] & ~SEP_WP_MASK) == 8'h00 &&
      tx_d[47:40] == (sdata_q & SEP_WP_MASK) && nbits_d == SEP_BITS_SR;
  endproperty
  a_wrsr_mask: assert property (p_wrsr_mask) else $error("status write frame wrong");

  property p_write_addr;
    start_d && (st_q == ST_RUN) && (cur_q == OP_WRITE) |->
      tx_d[47:32] == {top_q, blk_q, 2'b00} && tx_d[31:24] == buf_q[7:0] &&
      nbits_d == SEP_BITS_WD;
  endproperty
  a_write_addr: assert property (p_write_addr) else $error("word write frame wrong");

  property p_read_buf;
    (st_q == ST_RUN) && (cur_q == OP_READ) && eng_done |=>
      buf_q == {$past(eng_rx[7:0]), $past(eng_rx[15:8]),
                $past(eng_rx[23:16]), $past(eng_rx[31:24])};
  endproperty
  a_read_buf: assert property (p_read_buf) else $error("read data not in buffer");

  property p_rdsr;
    (st_q == ST_RUN) && (cur_q == OP_RDSR) && eng_done |=>
      csr_rd[SEP_SDATA_LSB +: 8] == $past(eng_rx[7:0]);
  endproperty
  a_rdsr: assert property (p_rdsr) else $error("status byte not copied");

  property p_latch_ops;
    start_d && (st_q == ST_RUN) && (cur_q == OP_WREN || cur_q == OP_WRDI) |->
      nbits_d == SEP_BITS_OP &&
      tx_d[55:48] == ((cur_q == OP_WREN) ? SPI_WREN : SPI_WRDI);
  endproperty
  a_latch_ops: assert property (p_latch_ops) else $error("latch opcode wrong");

  property p_wid_sig;
    (wid_q != WID_NONE) |-> pres_q == PRES_OK && pres_q != 2'h2;
  endproperty
  a_wid_sig: assert property (p_wid_sig) else $error("width without signature");

  property p_busy_hold;
    pend && csr_wr |=> $stable(op_q) && $stable(blk_q);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy write took effect");

  property p_rate;
    !eng_busy && (freq_q == SEP_FREQ_RST) |-> half == SEP_H0;
  endproperty
  a_rate: assert property (p_rate) else $error("default rate wrong");

  c_read: cover property ((st_q == ST_RUN) && (cur_q == OP_READ) && eng_done);
  c_write: cover property ((st_q == ST_RUN) && (cur_q == OP_WRITE) && eng_done);
  c_present: cover property (pres_q == PRES_OK);
  c_rdsr: cover property ((st_q == ST_RUN) && (cur_q == OP_RDSR) && eng_done);
endmodule

// File: common/sep_pkg.sv
// Purpose: constants and types for the serial memory command port
// Assumes: 50 MHz core clock, memory with two address bytes
// Notes: shared by the controller top and its serial shifter
package sep_pkg;
  localparam logic [11:0] SEP_CSR_OFS  = 12'h260;
  localparam logic [11:0] SEP_BUF_OFS  = 12'h264;
  localparam logic [11:0] SEP_FREQ_OFS = 12'h268;
  localparam int SEP_BLK_LSB   = 0;
  localparam int SEP_BLK_W     = 13;
  localparam int SEP_OP_LSB    = 13;
  localparam int SEP_PRES_LSB  = 16;
  localparam int SEP_PEND_BIT  = 18;
  localparam int SEP_TOP_BIT   = 20;
  localparam int SEP_WID_LSB   = 22;
  localparam int SEP_SDATA_LSB = 24;
  localparam logic [12:0] SEP_BLK_RST   = 13'h0000;
  localparam logic [7:0]  SEP_SDATA_RST = 8'h00;
  localparam logic [31:0] SEP_BUF_RST   = 32'h0000_0000;
  localparam logic [2:0]  SEP_FREQ_RST  = 3'h0;
  localparam logic [7:0]  SEP_WP_MASK   = 8'h8c;
  localparam logic [7:0]  SEP_SIG       = 8'h5a;
  localparam logic [7:0]  SEP_NO_DEV    = 8'hff;
  localparam logic [7:0]  SPI_WRSR  = 8'h01;
  localparam logic [7:0]  SPI_WRITE = 8'h02;
  localparam logic [7:0]  SPI_READ  = 8'h03;
  localparam logic [7:0]  SPI_WRDI  = 8'h04;
  localparam logic [7:0]  SPI_RDSR  = 8'h05;
  localparam logic [7:0]  SPI_WREN  = 8'h06;
  localparam logic [1:0]  PRES_NONE  = 2'h0;
  localparam logic [1:0]  PRES_OK    = 2'h1;
  localparam logic [1:0]  PRES_NOSIG = 2'h3;
  localparam logic [1:0]  WID_NONE   = 2'h0;
  localparam logic [1:0]  WID_TWO    = 2'h2;
  localparam logic [5:0]  SEP_BITS_OP  = 6'h08;
  localparam logic [5:0]  SEP_BITS_SR  = 6'h10;
  localparam logic [5:0]  SEP_BITS_SIG = 6'h20;
  localparam logic [5:0]  SEP_BITS_WD  = 6'h38;
  localparam int SEP_CLK_KHZ = 50000;
  localparam int SEP_F0_KHZ  = 1000;
  localparam int SEP_F1_KHZ  = 1980;
  localparam int SEP_F2_KHZ  = 5000;
  localparam int SEP_F3_KHZ  = 9620;
  localparam int SEP_F4_KHZ  = 12500;
  localparam int SEP_F5_KHZ  = 15600;
  // half serial clock periods in core cycles, rounded up
  localparam logic [4:0] SEP_H0 = 5'((SEP_CLK_KHZ + 2*SEP_F0_KHZ - 1) / (2*SEP_F0_KHZ));
  localparam logic [4:0] SEP_H1 = 5'((SEP_CLK_KHZ + 2*SEP_F1_KHZ - 1) / (2*SEP_F1_KHZ));
  localparam logic [4:0] SEP_H2 = 5'((SEP_CLK_KHZ + 2*SEP_F2_KHZ - 1) / (2*SEP_F2_KHZ));
  localparam logic [4:0] SEP_H3 = 5'((SEP_CLK_KHZ + 2*SEP_F3_KHZ - 1) / (2*SEP_F3_KHZ));
  localparam logic [4:0] SEP_H4 = 5'((SEP_CLK_KHZ + 2*SEP_F4_KHZ - 1) / (2*SEP_F4_KHZ));
  localparam logic [4:0] SEP_H5 = 5'((SEP_CLK_KHZ + 2*SEP_F5_KHZ - 1) / (2*SEP_F5_KHZ));
  typedef enum logic [2:0] {
    OP_RSV0 = 3'h0,
    OP_WRSR = 3'h1,
    OP_WRITE = 3'h2,
    OP_READ = 3'h3,
    OP_WRDI = 3'h4,
    OP_RDSR = 3'h5,
    OP_WREN = 3'h6,
    OP_RSV7 = 3'h7
  } sep_op_t;
  typedef enum logic [3:0] {
    ST_BOOT_SR = 4'h1,
    ST_BOOT_RD = 4'h2,
    ST_IDLE    = 4'h4,
    ST_RUN     = 4'h8
  } sep_state_t;
endpackage

// File: logic/sep_shift.sv
// Purpose: mode-0 serial shifter toward the external memory
// Assumes: tx is sent msb first, input sampled on the falling edge
// Notes: miso passes three flops and a two-of-two agreement filter
`timescale 1ns/1ps
module sep_shift
  import sep_pkg::*;
(
  input  wire logic        clk,      // core clock
  input  wire logic        rst_n,    // synchronised reset, active low
  input  wire logic        start,    // one-cycle start pulse
  input  wire logic [4:0]  half,     // half serial period in cycles
  input  wire logic [5:0]  nbits,    // bits in this frame
  input  wire logic [55:0] tx,       // frame, msb first
  output logic             busy,     // frame in progress
  output logic             done,     // one-cycle end of frame
  output logic [31:0]      rx,       // last 32 bits received
  output logic             sclk,     // serial clock pin
  output logic             cs_n,     // chip select pin, active low
  output logic             mosi,     // serial data out pin
  input  wire logic        miso      // serial data in pin
);
  logic [4:0]  cnt_q, cnt_d;
  logic [5:0]  bits_q, bits_d;
  logic [55:0] sh_q, sh_d;
  logic [31:0] rx_q, rx_d;
  logic        sclk_q, sclk_d;
  logic        cs_n_q, cs_n_d;
  logic        done_q, done_d;
  logic        s1_q, s2_q, s3_q, in_q, in_d;

  always_comb
  begin
    cnt_d  = cnt_q;
    bits_d = bits_q;
    sh_d   = sh_q;
    rx_d   = rx_q;
    sclk_d = sclk_q;
    cs_n_d = cs_n_q;
    done_d = 1'b0;
    in_d   = (s2_q == s3_q) ? s3_q : in_q;
    if (cs_n_q && start)
    begin
      cs_n_d = 1'b0;
      sh_d   = tx;
      bits_d = nbits;
      cnt_d  = half;
      sclk_d = 1'b0;
    end
    else if (!cs_n_q)
    begin
      if (cnt_q > 5'h01)
      begin
        cnt_d = cnt_q - 5'h01;
      end
      else
      begin
        cnt_d = half;
        if (!sclk_q)
        begin
          sclk_d = 1'b1;
        end
        else
        begin
          sclk_d = 1'b0;
          // filter output as it settles, so a two-cycle half period still lands
          rx_d   = {rx_q[30:0], in_d};
          sh_d   = {sh_q[54:0], 1'b0};
          bits_d = bits_q - 6'h01;
          if (bits_q == 6'h01)
          begin
            cs_n_d = 1'b1;
            done_d = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q  <= 5'h00;
      bits_q <= 6'h00;
      sh_q   <= 56'h0;
      rx_q   <= 32'h0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      done_q <= 1'b0;
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      in_q   <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      bits_q <= bits_d;
      sh_q   <= sh_d;
      rx_q   <= rx_d;
      sclk_q <= sclk_d;
      cs_n_q <= cs_n_d;
      done_q <= done_d;
      s1_q   <= miso;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      in_q   <= in_d;
    end
  end

  assign busy = !cs_n_q;
  assign done = done_q;
  assign rx   = rx_q;
  assign sclk = sclk_q;
  assign cs_n = cs_n_q;
  assign mosi = sh_q[55];
endmodule

// File: sim/sep_mem_model.sv
// Purpose: behavioural serial memory on the far side of the command port
// Assumes: mode 0, msb first, two address bytes, status bit 1 shows write enable
// Notes: gone models an empty socket whose data line is pulled up
`timescale 1ns/1ps
module sep_mem_model
  import sep_pkg::*;
(
  input  wire logic sclk,  // serial clock
  input  wire logic cs_n,  // chip select, active low
  input  wire logic mosi,  // data from controller
  input  wire logic gone,  // no memory fitted
  output logic      miso   // data to controller
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  sr  = 8'h00;
  logic [7:0]  op  = 8'h00;
  logic [7:0]  ob;
  logic [15:0] adr = 16'h0000;
  logic [31:0] sh  = 32'h0;
  logic        wel = 1'b0;
  logic        m_q = 1'b0;
  int          cnt = 0;
  initial mem[0] = SEP_SIG;
  assign miso = gone ? 1'b1 : m_q;
  always @(negedge cs_n) cnt = 0;
  always @(posedge sclk)
  begin
    if (!cs_n)
    begin
      sh = {sh[30:0], mosi};
      cnt = cnt + 1;
      if (cnt == 8) op = sh[7:0];
      if (cnt == 24) adr = sh[15:0];
      // stored only while the write-enable latch is set
      if (op == SPI_WRITE && wel && cnt > 24 && cnt % 8 == 0)
        mem[adr + 16'((cnt - 32) / 8)] = sh[7:0];
    end
  end
  always @(negedge sclk)
  begin
    if (!cs_n)
    begin
      ob = (op == SPI_RDSR) ? {sr[7:2], wel, 1'b0} : mem[adr + 16'((cnt - 24) / 8)];
      if ((op == SPI_RDSR && cnt >= 8) || (op == SPI_READ && cnt >= 24))
        m_q = ob[7 - cnt % 8];
      else
        m_q = ~m_q;
    end
  end
  always @(posedge cs_n)
  begin
    m_q = ~m_q;
    if (op == SPI_WREN && cnt == 8) wel = 1'b1;
    if (op == SPI_WRDI && cnt == 8) wel = 1'b0;
    // keeps bits 7 to 2 of what it is sent, so an unmasked status write shows up
    if (op == SPI_WRSR && cnt == 16 && wel) sr = sh[7:0] & 8'hfc;
    if (op != SPI_RDSR && op != SPI_READ && cnt > 8) wel = 1'b0;
    op = 8'h00;
  end
endmodule

// File: sim/tb_top.sv
// Purpose: self-checking bench for the serial memory command port
// Assumes: registers written and read with one-cycle strobes
// Notes: memory contents survive controller resets for the probe cases
`timescale 1ns/1ps
module tb_top;
  import sep_pkg::*;
  typedef struct { logic [11:0] a; logic [31:0] w; logic [31:0] e; } sep_row_t;
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        REG_WR = 1'b0;
  logic        REG_RD = 1'b0;
  logic [11:0] REG_ADDR = 12'h000;
  logic [31:0] REG_WDATA = 32'h0;
  logic [31:0] REG_RDATA;
  logic        MEM_SCLK, MEM_CS_N, MEM_MOSI, MEM_MISO;
  logic        GONE = 1'b0;
  logic [31:0] v;
  int          n;
  int          bad_count = 0;
  int          total_checks = 0;
  logic [4:0]  hexp [8] = '{SEP_H0, SEP_H1, SEP_H2, SEP_H3, SEP_H4, SEP_H5, SEP_H5, SEP_H0};
  sep_row_t    rows [6] = '{
    '{12'h268, 32'h0000_00fd, 32'h0000_0005},
    '{12'h268, 32'h0000_0000, 32'h0000_0000},
    '{12'h26c, 32'hffff_ffff, 32'h0000_0000},
    '{12'h264, 32'ha5a5_0ff0, 32'ha5a5_0ff0},
    '{12'h260, 32'h3cff_fabc, 32'h3c91_fabc},
    '{12'h260, 32'h0000_0000, 32'h0081_0000}};
  sep_top dut_u (.CLK(CLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .MEM_SCLK(MEM_SCLK), .MEM_CS_N(MEM_CS_N), .MEM_MOSI(MEM_MOSI), .MEM_MISO(MEM_MISO));
  sep_mem_model mem_u (.sclk(MEM_SCLK), .cs_n(MEM_CS_N), .mosi(MEM_MOSI), .gone(GONE),
    .miso(MEM_MISO));
  initial
  begin
    forever #10 CLK = ~CLK;
  end
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge CLK);
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge CLK);
    REG_WR = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(negedge CLK);
    REG_RD = 1'b1;
    REG_ADDR = a;
    @(negedge CLK);
    REG_RD = 1'b0;
    @(negedge CLK);
    d = REG_RDATA;
  endtask
  task automatic idle();
    logic [31:0] s;
    s = 32'hffff_ffff;
    for (int i = 0; i < 3000 && s[SEP_PEND_BIT] !== 1'b0; i++) rd(SEP_CSR_OFS, s);
    chk({31'h0, s[SEP_PEND_BIT]}, 32'h0);
  endtask
  task automatic cmd(input logic [2:0] op, input logic top, input logic [12:0] blk);
    logic [31:0] s;
    wr(SEP_CSR_OFS, {8'h00, 3'h0, top, 4'h0, op, blk});
    rd(SEP_CSR_OFS, s);
    chk({31'h0, s[SEP_PEND_BIT]}, 32'h1);
    idle();
  endtask
  task automatic do_rst();
    @(negedge CLK);
    RST_N = 1'b0;
    repeat (11) @(negedge CLK);
    chk(REG_RDATA, 32'h0);
    chk({29'h0, MEM_CS_N, MEM_SCLK, MEM_MOSI}, 32'h4);
    @(negedge CLK);
    RST_N = 1'b1;
    // internal reset copy needs two edges before the first read counts
    repeat (2) @(negedge CLK);
    rd(SEP_CSR_OFS, v);
    chk({31'h0, v[SEP_PEND_BIT]}, 32'h1);
    idle();
  endtask
  initial
  begin
    #(1_600_000);
    bad_count++;
    end_sim();
  end
  initial
  begin
    do_rst();
    rd(SEP_CSR_OFS, v);
    chk(v, 32'h0081_0000);
    rd(SEP_BUF_OFS, v);
    chk(v, SEP_BUF_RST);
    rd(SEP_FREQ_OFS, v);
    chk(v, 32'h0);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, v);
      chk(v, rows[i].e);
    end
    // serial clock high time per rate code, then the latch it set
    for (int c = 0; c < 8; c++)
    begin
      wr(SEP_FREQ_OFS, 32'(c));
      wr(SEP_CSR_OFS, {16'h0, OP_WREN, 13'h0});
      n = 0;
      for (int i = 0; i < 300 && MEM_SCLK !== 1'b1; i++) @(negedge CLK);
      for (int i = 0; i < 60 && MEM_SCLK === 1'b1; i++)
      begin
        @(negedge CLK);
        n++;
      end
      chk(32'(n), {27'h0, hexp[c]});
      idle();
      cmd(OP_RDSR, 1'b0, 13'h0);
      rd(SEP_CSR_OFS, v);
      chk({24'h0, v[31:24]}, 32'h02);
    end
    wr(SEP_FREQ_OFS, 32'h2);
    cmd(OP_WRDI, 1'b0, 13'h0);
    cmd(OP_RDSR, 1'b0, 13'h0);
    rd(SEP_CSR_OFS, v);
    chk({24'h0, v[31:24]}, 32'h00);
    cmd(OP_WREN, 1'b0, 13'h0);
    wr(SEP_CSR_OFS, {8'hff, 8'h0, OP_WRSR, 13'h0});
    idle();
    cmd(OP_RDSR, 1'b0, 13'h0);
    rd(SEP_CSR_OFS, v);
    chk({24'h0, v[31:24]}, {24'h0, SEP_WP_MASK});
    // top block bit separates two words at the highest block address
    wr(SEP_BUF_OFS, 32'h1122_3344);
    cmd(OP_WREN, 1'b0, 13'h0);
    cmd(OP_WRITE, 1'b1, 13'h1fff);
    wr(SEP_BUF_OFS, 32'h5566_7788);
    cmd(OP_WREN, 1'b0, 13'h0);
    cmd(OP_WRITE, 1'b0, 13'h1fff);
    chk({24'h0, mem_u.mem[16'hfffc]}, 32'h44);
    chk({24'h0, mem_u.mem[16'h7fff]}, 32'h55);
    wr(SEP_BUF_OFS, 32'h0);
    wr(SEP_CSR_OFS, {11'h0, 1'b1, 4'h0, OP_READ, 13'h1fff});
    wr(SEP_BUF_OFS, 32'hdead_beef);
    wr(SEP_CSR_OFS, {16'h0, OP_WRITE, 13'h0005});
    idle();
    rd(SEP_BUF_OFS, v);
    chk(v, 32'h1122_3344);
    rd(SEP_CSR_OFS, v);
    chk(v & 32'h0010_ffff, 32'h0010_7fff);
    cmd(OP_READ, 1'b0, 13'h1fff);
    rd(SEP_BUF_OFS, v);
    chk(v, 32'h5566_7788);
    // spoil the signature, then take the memory away
    wr(SEP_BUF_OFS, 32'h0000_00a5);
    cmd(OP_WREN, 1'b0, 13'h0);
    cmd(OP_WRITE, 1'b0, 13'h0);
    do_rst();
    rd(SEP_CSR_OFS, v);
    chk(v & 32'h00c3_0000, 32'h0003_0000);
    GONE = 1'b1;
    do_rst();
    rd(SEP_CSR_OFS, v);
    chk(v & 32'h00c3_0000, 32'h0);
    end_sim();
  end
endmodule
